// ===== hdl/ccr_core_control.sv
// Core control register of the DSP core, with its plain register port
// Summary of operation
// - The two-bit multiply sign mode gives signed 00, unsigned 01, mixed 10, reserved 11.
// - Writing one to bit 11 ends the running loop after its current pass; it reads as zero.
// - The read-only depth field shows how many hardware loops are active, zero to seven.
// - Bit 7 turns saturation of accumulator A results on or off.
// - Bit 6 turns saturation of accumulator B results on or off.
// - Bit 5 turns saturation of DSP data-space writes on, and is one after reset.
// - Bit 4 picks 9.31 super saturation when set and 1.31 normal saturation when clear.
// - Bit 3 is one while the priority level is above 7; software may clear it.
// - The four-bit priority level is bit 3 above the three status register priority bits.
`timescale 1ns/1ns
`include "ccr_regs.svh"

module ccr_core_control (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [`CCR_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [2:0] loop_nest_depth_i,
  input wire logic fixed_address_status_i,
  input wire logic [2:0] status_priority_i,
  input wire logic priority_msb_set_i,
  input wire logic priority_msb_clr_i,
  output ccr_pkg::ccr_ctrl_t ctrl_o,
  output logic loop_early_exit_o,
  output logic [3:0] cpu_priority_level_o
);

  // ----------------------------------------
  // Reset image
  // ----------------------------------------

  // Whole register image after reset
  localparam logic [15:0] ctrl_img_rst = `CCR_CORE_CONTROL_RST;

  // Writable fields picked out of the reset image
  localparam ccr_pkg::ccr_ctrl_t ctrl_rst = '{
    var_latency: ctrl_img_rst[`CCR_BIT_LATENCY],
    multiply_sign_mode:
      ccr_pkg::ccr_mul_mode_t'(ctrl_img_rst[`CCR_BIT_SIGN_HI:`CCR_BIT_SIGN_LO]),
    accum_a_sat_en: ctrl_img_rst[`CCR_BIT_SAT_A],
    accum_b_sat_en: ctrl_img_rst[`CCR_BIT_SAT_B],
    data_write_sat_en: ctrl_img_rst[`CCR_BIT_SAT_DW],
    saturation_width_sel: ctrl_img_rst[`CCR_BIT_SAT_WIDTH],
    rounding_mode: ctrl_img_rst[`CCR_BIT_ROUND],
    int_frac_mode: ctrl_img_rst[`CCR_BIT_INT_FRAC]
  };

  // ----------------------------------------
  // Register state
  // ----------------------------------------

  // Writable fields, the struct handed to the core
  ccr_pkg::ccr_ctrl_t ctrl_q;
  ccr_pkg::ccr_ctrl_t ctrl_d;
  // Priority level top bit
  logic prio_msb_q;
  logic prio_msb_d;
  // Early loop exit request
  logic exit_q;
  logic exit_d;
  // Registered read data
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  // Registered four-bit priority level
  logic [3:0] level_q;
  logic [3:0] level_d;
  // Decoded strobes and assembled read view
  logic wr_hit;
  logic rd_hit;
  logic [15:0] view;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Only the one mapped offset takes a strobe
  assign wr_hit = wr_i && (addr_i == `CCR_CORE_CONTROL_OFS);
  assign rd_hit = rd_i && (addr_i == `CCR_CORE_CONTROL_OFS);

  // ----------------------------------------
  // Writable control fields
  // ----------------------------------------

  // Next field values, all writable fields replaced by a write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_hit) begin
      ctrl_d.var_latency = wdata_i[`CCR_BIT_LATENCY];
      ctrl_d.multiply_sign_mode =
        ccr_pkg::ccr_mul_mode_t'(wdata_i[`CCR_BIT_SIGN_HI:`CCR_BIT_SIGN_LO]);
      ctrl_d.accum_a_sat_en = wdata_i[`CCR_BIT_SAT_A];
      ctrl_d.accum_b_sat_en = wdata_i[`CCR_BIT_SAT_B];
      ctrl_d.data_write_sat_en = wdata_i[`CCR_BIT_SAT_DW];
      ctrl_d.saturation_width_sel = wdata_i[`CCR_BIT_SAT_WIDTH];
      ctrl_d.rounding_mode = wdata_i[`CCR_BIT_ROUND];
      ctrl_d.int_frac_mode = wdata_i[`CCR_BIT_INT_FRAC];
    end
  end

  // Field register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= ctrl_rst;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------
  // Early loop exit request
  // ----------------------------------------

  // One-cycle request on a written one; a written zero has no effect
  // Bit never stored, so it always reads back as zero
  always_comb begin
    exit_d = 1'b0;
    if (wr_hit) begin
      exit_d = wdata_i[`CCR_BIT_EARLY_EXIT];
    end
  end

  // Pulse register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      exit_q <= `CCR_EXIT_RST;
    end else begin
      exit_q <= exit_d;
    end
  end

  // ----------------------------------------
  // Priority level top bit
  // ----------------------------------------

  // Software may only clear the bit; a written one is ignored
  // Core raising the level wins over any clear in the same cycle
  always_comb begin
    prio_msb_d = prio_msb_q;
    if (wr_hit && !wdata_i[`CCR_BIT_PRIO_MSB]) begin
      prio_msb_d = 1'b0;
    end
    if (priority_msb_set_i) begin
      prio_msb_d = 1'b1;
    end else if (priority_msb_clr_i) begin
      prio_msb_d = 1'b0;
    end
  end

  // Top bit register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prio_msb_q <= `CCR_PRIO_MSB_RST;
    end else begin
      prio_msb_q <= prio_msb_d;
    end
  end

  // ----------------------------------------
  // Four-bit priority level
  // ----------------------------------------

  // Next top bit used so the level moves with it, not a cycle later
  always_comb begin
    level_d = {prio_msb_d, status_priority_i};
  end

  // Level register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      level_q <= `CCR_LEVEL_RST;
    end else begin
      level_q <= level_d;
    end
  end

  // ----------------------------------------
  // Read view
  // ----------------------------------------

  // Stored fields, live core status, zero for bits 14 and 11
  always_comb begin
    view = 16'h0000;
    view[`CCR_BIT_LATENCY] = ctrl_q.var_latency;
    view[`CCR_BIT_UNIMPL] = 1'b0;
    view[`CCR_BIT_SIGN_HI:`CCR_BIT_SIGN_LO] = ctrl_q.multiply_sign_mode;
    view[`CCR_BIT_EARLY_EXIT] = 1'b0;
    view[`CCR_BIT_DEPTH_HI:`CCR_BIT_DEPTH_LO] = loop_nest_depth_i;
    view[`CCR_BIT_SAT_A] = ctrl_q.accum_a_sat_en;
    view[`CCR_BIT_SAT_B] = ctrl_q.accum_b_sat_en;
    view[`CCR_BIT_SAT_DW] = ctrl_q.data_write_sat_en;
    view[`CCR_BIT_SAT_WIDTH] = ctrl_q.saturation_width_sel;
    view[`CCR_BIT_PRIO_MSB] = prio_msb_q;
    view[`CCR_BIT_FIXED_ADDR] = fixed_address_status_i;
    view[`CCR_BIT_ROUND] = ctrl_q.rounding_mode;
    view[`CCR_BIT_INT_FRAC] = ctrl_q.int_frac_mode;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------

  // View for one cycle after a mapped read, zero otherwise
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_hit) begin
      rdata_d = view;
    end
  end

  // Read data register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_q <= `CCR_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Outputs straight from flip-flops
  assign ctrl_o = ctrl_q;
  assign loop_early_exit_o = exit_q;
  assign cpu_priority_level_o = level_q;
  assign rdata_o = rdata_q;

endmodule : ccr_core_control

// ===== hdl/ccr_pkg.sv
// Types shared by the core control register block
package ccr_pkg;

  // Multiply sign mode encodings
  typedef enum logic [1:0] {
    CCR_MUL_SIGNED = 2'h0,
    CCR_MUL_UNSIGNED = 2'h1,
    CCR_MUL_MIXED = 2'h2,
    CCR_MUL_RESERVED = 2'h3
  } ccr_mul_mode_t;

  // Settings that the DSP engine and core consume
  typedef struct packed {
    logic var_latency;
    ccr_mul_mode_t multiply_sign_mode;
    logic accum_a_sat_en;
    logic accum_b_sat_en;
    logic data_write_sat_en;
    logic saturation_width_sel;
    logic rounding_mode;
    logic int_frac_mode;
  } ccr_ctrl_t;

endpackage : ccr_pkg

// ===== hdl/ccr_regs.svh
// Register offsets, field positions and reset values of the core control register
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

`define CCR_ADDR_W 4
`define CCR_CORE_CONTROL_OFS 4'h0
`define CCR_CORE_CONTROL_RST 16'h0020
`define CCR_PRIO_MSB_RST 1'b0
`define CCR_EXIT_RST 1'b0
`define CCR_RDATA_RST 16'h0000
`define CCR_LEVEL_RST 4'h0
`define CCR_BIT_LATENCY 15
`define CCR_BIT_UNIMPL 14
`define CCR_BIT_SIGN_HI 13
`define CCR_BIT_SIGN_LO 12
`define CCR_BIT_EARLY_EXIT 11
`define CCR_BIT_DEPTH_HI 10
`define CCR_BIT_DEPTH_LO 8
`define CCR_BIT_SAT_A 7
`define CCR_BIT_SAT_B 6
`define CCR_BIT_SAT_DW 5
`define CCR_BIT_SAT_WIDTH 4
`define CCR_BIT_PRIO_MSB 3
`define CCR_BIT_FIXED_ADDR 2
`define CCR_BIT_ROUND 1
`define CCR_BIT_INT_FRAC 0

`endif

// ===== sim/ccr_core_control_sva.sv
// Assertions on the ports of the core control register
`timescale 1ns/1ns
module ccr_core_control_sva (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [2:0] loop_nest_depth_i,
  input wire logic fixed_address_status_i,
  input wire logic [2:0] status_priority_i,
  input wire logic priority_msb_set_i,
  input wire logic priority_msb_clr_i,
  input wire ccr_pkg::ccr_ctrl_t ctrl_o,
  input wire logic loop_early_exit_o,
  input wire logic [3:0] cpu_priority_level_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic w;
  // Write taken at the one mapped address
  assign w = wr_i && addr_i == 4'h0;
  logic r;
  // Read taken at the one mapped address
  assign r = rd_i && addr_i == 4'h0;
  property p_lat; w |=> ctrl_o.var_latency == $past(wdata_i[15]); endproperty
  a_lat: assert property (p_lat) else $error("latency");
  property p_mul; w |=> ctrl_o.multiply_sign_mode == $past(wdata_i[13:12]); endproperty
  a_mul: assert property (p_mul) else $error("sign mode");
  property p_exit; loop_early_exit_o == $past(w && wdata_i[11]); endproperty
  a_exit: assert property (p_exit) else $error("exit pulse");
  property p_sat; w |=> {ctrl_o.accum_a_sat_en, ctrl_o.accum_b_sat_en} == $past(wdata_i[7:6]);
  endproperty
  a_sat: assert property (p_sat) else $error("accum sat");
  property p_dw; w |=>
    {ctrl_o.data_write_sat_en, ctrl_o.saturation_width_sel} == $past(wdata_i[5:4]);
  endproperty
  a_dw: assert property (p_dw) else $error("write sat");
  property p_msb; priority_msb_set_i |=> cpu_priority_level_o[3]; endproperty
  a_msb: assert property (p_msb) else $error("level msb");
  property p_prio; !reset_i |=> cpu_priority_level_o[2:0] == $past(status_priority_i); endproperty
  a_prio: assert property (p_prio) else $error("level low");
  property p_rd; rd_i |=> !rdata_o[14] && !rdata_o[11] &&
    ($past(addr_i) == 4'h0 || rdata_o == 16'h0000);
  endproperty
  a_rd: assert property (p_rd) else $error("read view");
  property p_depth; r |=> rdata_o[10:8] == $past(loop_nest_depth_i) &&
    rdata_o[2] == $past(fixed_address_status_i);
  endproperty
  a_depth: assert property (p_depth) else $error("read status");
  property p_clr; w && !wdata_i[3] && !priority_msb_set_i |=> !cpu_priority_level_o[3];
  endproperty
  a_clr: assert property (p_clr) else $error("level msb write clear");
  property p_hwclr; priority_msb_clr_i && !priority_msb_set_i |=> !cpu_priority_level_o[3];
  endproperty
  a_hwclr: assert property (p_hwclr) else $error("level msb core clear");
endmodule : ccr_core_control_sva
bind ccr_core_control ccr_core_control_sva u_sva (.*);

// ===== sim/ccr_core_model.sv
// Behavioural core model counting active hardware loops
`timescale 1ns/1ns
module ccr_core_model (
  input wire logic core_clk_i,
  input wire logic push_i,
  input wire logic exit_i,
  output logic [2:0] depth_o
);
  initial depth_o = 3'h0;
  // Loop entry adds one, early exit retires one
  always @(posedge core_clk_i) depth_o <= depth_o + push_i - exit_i;
endmodule : ccr_core_model

// ===== sim/test_ccr_core_control.sv
// Self-checking bench of the core control register
`timescale 1ns/1ns
module test_ccr_core_control;
  logic core_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, push = 0, set = 0, exit_o;
  logic clr = 0, fa = 0;
  logic [3:0] addr_i = 4'h0, lvl;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic [2:0] depth, prio = 3'h0;
  ccr_pkg::ccr_ctrl_t ctrl;
  int fails = 0, checks_done = 0, cyc = 0;
  ccr_core_control u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .loop_nest_depth_i(depth),
    .fixed_address_status_i(fa), .status_priority_i(prio), .priority_msb_set_i(set),
    .priority_msb_clr_i(clr), .ctrl_o(ctrl), .loop_early_exit_o(exit_o),
    .cpu_priority_level_o(lvl));
  ccr_core_model u_core (.core_clk_i(core_clk_i), .push_i(push), .exit_i(exit_o), .depth_o(depth));
  initial forever #10 core_clk_i = ~core_clk_i;
  // Cycle ceiling against hangs
  always @(posedge core_clk_i) if (++cyc == 3000) begin
    fails++;
    results;
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge core_clk_i) wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge core_clk_i) rd_i <= 1'b0;
    #1 chk("rdata", rdata_o, e);
  endtask : rd
  task results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(4'h0, 16'h0020);
    repeat (2) @(posedge core_clk_i) push <= 1'b1;
    @(posedge core_clk_i) push <= 1'b0;
    wr(4'h0, 16'hFFFF);
    #1 chk("ctrl", {7'h00, ctrl}, 16'h01FF);
    chk("exit", {15'h0000, exit_o}, 16'h0001);
    rd(4'h0, 16'hB1F3);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 16'(i) << 12);
      #1 chk("mul", 16'(ctrl.multiply_sign_mode), 16'(i));
    end
    wr(4'h7, 16'hFFFF);
    rd(4'h5, 16'h0000);
    rd(4'h0, 16'h3100);
    @(posedge core_clk_i) {prio, set} <= {3'h5, 1'b1};
    @(posedge core_clk_i) set <= 1'b0;
    #1 chk("lvl", {12'h000, lvl}, 16'h000D);
    wr(4'h0, 16'h0000);
    #1 chk("lvl", {12'h000, lvl}, 16'h0005);
    @(posedge core_clk_i) fa <= 1'b1;
    wr(4'h0, 16'h4704);
    rd(4'h0, 16'h0104);
    @(posedge core_clk_i) {fa, set} <= 2'b01;
    @(posedge core_clk_i) {set, clr} <= 2'b01;
    #1 chk("lvl", {12'h000, lvl}, 16'h000D);
    @(posedge core_clk_i) {set, clr} <= 2'b11;
    #1 chk("lvl", {12'h000, lvl}, 16'h0005);
    @(posedge core_clk_i) {set, clr} <= 2'b00;
    #1 chk("lvl", {12'h000, lvl}, 16'h000D);
    @(posedge core_clk_i) reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(4'h0, 16'h0120);
    chk("lvl", {12'h000, lvl}, 16'h0005);
    results;
  end
endmodule : test_ccr_core_control
